// File: core/cfs_pkg.sv
// Package of field layout, reset values and codes for the CAN FD protocol status word
`default_nettype none
package cfs_pkg;
	localparam int unsigned WORD_W          = 32;
	localparam int unsigned POS_W           = 7;
	localparam int unsigned CODE_W          = 3;
	localparam int unsigned ACT_W           = 2;
	localparam int unsigned POS_LSB         = 16;
	localparam int unsigned POS_MSB         = 22;
	localparam int unsigned EXC_BIT         = 14;
	localparam int unsigned FDF_BIT         = 13;
	localparam int unsigned BRS_BIT         = 12;
	localparam int unsigned ESI_BIT         = 11;
	localparam int unsigned DCODE_LSB       = 8;
	localparam int unsigned DCODE_MSB       = 10;
	localparam int unsigned BOFF_BIT        = 7;
	localparam int unsigned WARN_BIT        = 6;
	localparam int unsigned PASS_BIT        = 5;
	localparam int unsigned ACT_LSB         = 3;
	localparam int unsigned ACT_MSB         = 4;
	localparam int unsigned NCODE_LSB       = 0;
	localparam int unsigned NCODE_MSB       = 2;
	localparam logic [POS_W-1:0]  POS_MAX   = 7'h7F;
	localparam logic [POS_W-1:0]  POS_RESET = 7'h00;
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000707;

	typedef enum logic [CODE_W-1:0] {
		CFS_ERR_NONE   = 3'h0,
		CFS_ERR_STUFF  = 3'h1,
		CFS_ERR_FORM   = 3'h2,
		CFS_ERR_ACK    = 3'h3,
		CFS_ERR_BIT1   = 3'h4,
		CFS_ERR_BIT0   = 3'h5,
		CFS_ERR_CRC    = 3'h6,
		CFS_ERR_NOCHG  = 3'h7
	} cfs_err_code_t;

	// Events reported by the protocol engine, each valid a one-cycle pulse
	typedef struct packed {
		logic                exception;
		logic                fd_rx_valid;
		logic                fd_rx_brs;
		logic                fd_rx_esi;
		logic                data_phase_enter;
		logic                bus_event_valid;
		cfs_err_code_t       bus_event_code;
		logic                delay_meas_valid;
		logic                delay_meas_brs_tx;
		logic [POS_W-1:0]    delay_meas;
	} cfs_engine_evt_t;

	// Levels reported by the protocol engine
	typedef struct packed {
		logic                bus_off;
		logic                warning;
		logic                passive;
		logic [ACT_W-1:0]    activity;
	} cfs_engine_lvl_t;

	// Host access strobes
	typedef struct packed {
		logic                rd;
		logic                wr;
		logic [WORD_W-1:0]   wdata;
	} cfs_host_req_t;
endpackage
`default_nettype wire

// File: core/cfs_flag_cell.sv
// Sticky flag cell, set has priority over clear
`default_nettype none
module cfs_flag_cell (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	typedef struct packed {
		logic flag;
	} cfs_cell_state_t;

	cfs_cell_state_t st;
	cfs_cell_state_t next_st;

	always_comb begin
		next_st = st;
		if (set) begin
			next_st.flag = 1'b1;
		end else if (clr) begin
			next_st.flag = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.flag;
endmodule // cfs_flag_cell
`default_nettype wire

// File: core/cfs_protocol_status.sv
// CAN FD protocol status word: delay position, event flags, error codes, bus-off
// Functional notes
// - Position field is measured delay plus offset
// - Position counted in quanta, clamped to 127
// - Exception flag set by event, cleared by read
// - FD-received flag set on any FD frame
// - Cleared FD-received flag stays zero until next
// - BRS copy updated together with FD-received flag
// - ESI copy updated together with FD-received flag
// - Data-phase error code field, resets to seven
// - Data code gets zero only from a data-phase none event
// - Bus-off bit follows engine bus-off state
// - Codes: none,stuff,form,ack,bit1,bit0,crc,nochange
// - Read reinitialises nominal code to seven
// - Event after BRS data phase goes to data code
`default_nettype none
module cfs_protocol_status (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire cfs_pkg::cfs_engine_evt_t evt,
	input  wire cfs_pkg::cfs_engine_lvl_t lvl,
	input  wire logic [cfs_pkg::POS_W-1:0] delay_comp_offset,
	input  wire cfs_pkg::cfs_host_req_t   host,
	output logic [cfs_pkg::WORD_W-1:0]    rd_data,
	output logic                          rd_valid
);
	typedef struct packed {
		logic [cfs_pkg::POS_W-1:0]   delay_comp_position;
		logic                        last_fd_brs_flag;
		logic                        last_fd_esi_flag;
		cfs_pkg::cfs_err_code_t      data_phase_error_code;
		cfs_pkg::cfs_err_code_t      nominal_error_code;
		logic                        data_phase_armed;
		logic [cfs_pkg::WORD_W-1:0]  rd_data;
		logic                        rd_valid;
	} cfs_state_t;

	cfs_state_t                  st;
	cfs_state_t                  next_st;
	logic                        protocol_exception_flag;
	logic                        fd_frame_received_flag;
	logic [cfs_pkg::POS_W:0]     pos_sum;
	logic [cfs_pkg::WORD_W-1:0]  word;
	logic                        fdf_clr;

	// Host clears the FD-received flag by writing one to its bit
	assign fdf_clr = host.wr && host.wdata[cfs_pkg::FDF_BIT];

	cfs_flag_cell u_exception (
		.clock (clock),
		.rst   (rst),
		.set   (evt.exception),
		.clr   (host.rd),
		.q     (protocol_exception_flag)
	);

	cfs_flag_cell u_fd_received (
		.clock (clock),
		.rst   (rst),
		.set   (evt.fd_rx_valid),
		.clr   (fdf_clr),
		.q     (fd_frame_received_flag)
	);

	// Word as seen by the host; unlisted bits stay zero
	always_comb begin
		word = '0;
		word[cfs_pkg::POS_MSB:cfs_pkg::POS_LSB]     = st.delay_comp_position;
		word[cfs_pkg::EXC_BIT]                      = protocol_exception_flag;
		word[cfs_pkg::FDF_BIT]                      = fd_frame_received_flag;
		word[cfs_pkg::BRS_BIT]                      = st.last_fd_brs_flag;
		word[cfs_pkg::ESI_BIT]                      = st.last_fd_esi_flag;
		word[cfs_pkg::DCODE_MSB:cfs_pkg::DCODE_LSB] = st.data_phase_error_code;
		word[cfs_pkg::BOFF_BIT]                     = lvl.bus_off;
		word[cfs_pkg::WARN_BIT]                     = lvl.warning;
		word[cfs_pkg::PASS_BIT]                     = lvl.passive;
		word[cfs_pkg::ACT_MSB:cfs_pkg::ACT_LSB]     = lvl.activity;
		word[cfs_pkg::NCODE_MSB:cfs_pkg::NCODE_LSB] = st.nominal_error_code;
	end

	always_comb begin
		next_st = st;
		pos_sum = {1'b0, evt.delay_meas} + {1'b0, delay_comp_offset};
		next_st.rd_valid = host.rd;
		if (host.rd) begin
			next_st.rd_data = word;
			next_st.nominal_error_code = cfs_pkg::CFS_ERR_NOCHG;
			next_st.data_phase_error_code = cfs_pkg::CFS_ERR_NOCHG;
		end
		if (evt.delay_meas_valid && evt.delay_meas_brs_tx) begin
			if (pos_sum[cfs_pkg::POS_W]) begin
				next_st.delay_comp_position = cfs_pkg::POS_MAX;
			end else begin
				next_st.delay_comp_position = pos_sum[cfs_pkg::POS_W-1:0];
			end
		end
		if (evt.fd_rx_valid) begin
			next_st.last_fd_brs_flag = evt.fd_rx_brs;
			next_st.last_fd_esi_flag = evt.fd_rx_esi;
		end
		if (evt.data_phase_enter) begin
			next_st.data_phase_armed = 1'b1;
		end
		// A bus event in the same cycle as a read wins over the reinit
		if (evt.bus_event_valid) begin
			if (st.data_phase_armed || evt.data_phase_enter) begin
				next_st.data_phase_error_code = evt.bus_event_code;
				next_st.data_phase_armed = 1'b0;
			end else begin
				next_st.nominal_error_code = evt.bus_event_code;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st.delay_comp_position   <= cfs_pkg::POS_RESET;
			st.last_fd_brs_flag      <= 1'b0;
			st.last_fd_esi_flag      <= 1'b0;
			st.data_phase_error_code <= cfs_pkg::CFS_ERR_NOCHG;
			st.nominal_error_code    <= cfs_pkg::CFS_ERR_NOCHG;
			st.data_phase_armed      <= 1'b0;
			st.rd_data               <= cfs_pkg::WORD_RESET;
			st.rd_valid              <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data  = st.rd_data;
	assign rd_valid = st.rd_valid;
endmodule // cfs_protocol_status
`default_nettype wire

// File: dv/cfs_status_asserts.sv
// Concurrent checks on the protocol status word ports
`default_nettype none
module cfs_status_asserts (
	input wire logic                       clock,
	input wire logic                       rst,
	input wire cfs_pkg::cfs_engine_evt_t   evt,
	input wire cfs_pkg::cfs_engine_lvl_t   lvl,
	input wire logic [cfs_pkg::POS_W-1:0]  delay_comp_offset,
	input wire cfs_pkg::cfs_host_req_t     host,
	input wire logic [cfs_pkg::WORD_W-1:0] rd_data,
	input wire logic                       rd_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] pos_sum;
	assign pos_sum = {1'b0, evt.delay_meas} + {1'b0, delay_comp_offset};
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	rsvd_zero_a: assert property (rd_valid |-> rd_data[31:23] == 9'h000 && !rd_data[15])
		else $error("reserved bit set");
	bus_off_a: assert property ($stable(lvl.bus_off) && host.rd |=>
		rd_data[7] == $past(lvl.bus_off)) else $error("bus-off bit wrong");
	exc_set_a: assert property (evt.exception ##1 !host.rd ##1 host.rd |=> rd_data[14])
		else $error("exception flag lost");
	exc_clr_a: assert property (host.rd && !evt.exception ##1 !evt.exception ##1 host.rd
		|=> !rd_data[14]) else $error("exception flag kept");
	fd_copy_a: assert property (evt.fd_rx_valid ##1 !evt.fd_rx_valid && !host.wr
		##1 host.rd |=>
		rd_data[13:11] == {1'b1, $past(evt.fd_rx_brs, 3), $past(evt.fd_rx_esi, 3)})
		else $error("fd flags wrong");
	delay_pos_a: assert property (evt.delay_meas_valid && evt.delay_meas_brs_tx
		##1 !evt.delay_meas_valid ##1 host.rd |=>
		rd_data[22:16] == ($past(pos_sum, 3) > 8'h7F ? 7'h7F : $past(pos_sum[6:0], 3)))
		else $error("delay position wrong");
	code_reinit_a: assert property (host.rd && !evt.bus_event_valid ##1 !evt.bus_event_valid
		##1 host.rd |=> rd_data[10:8] == 3'h7 && rd_data[2:0] == 3'h7)
		else $error("codes not reset");
	data_code_a: assert property (host.rd && !evt.bus_event_valid ##1 !evt.bus_event_valid
		##1 evt.data_phase_enter && evt.bus_event_valid ##1 !evt.bus_event_valid && !host.rd
		##1 host.rd |=> rd_data[10:8] == $past(evt.bus_event_code, 3) && rd_data[2:0] == 3'h7)
		else $error("data code wrong");
endmodule // cfs_status_asserts
bind cfs_protocol_status cfs_status_asserts chk (.clock, .rst, .evt, .lvl, .delay_comp_offset,
	.host, .rd_data, .rd_valid);
`default_nettype wire

// File: dv/cfs_engine_model.sv
// Protocol engine stand-in that issues one-cycle event pulses
`default_nettype none
module cfs_engine_model (
	input  wire logic                   clock,
	output var cfs_pkg::cfs_engine_evt_t evt
);
	timeunit 1ns;
	timeprecision 1ns;
	initial evt = '0;
	task automatic send(input cfs_pkg::cfs_engine_evt_t e);
		@(posedge clock);
		evt <= e;
		@(posedge clock);
		evt <= '0;
	endtask
endmodule // cfs_engine_model
`default_nettype wire

// File: dv/cfs_tb.sv
// Self-checking bench for the protocol status word
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                       clock;
	logic                       rst;
	cfs_pkg::cfs_engine_evt_t   evt;
	cfs_pkg::cfs_engine_lvl_t   lvl;
	logic [6:0]                 offset;
	cfs_pkg::cfs_host_req_t     host;
	logic [31:0]                rd_data;
	logic                       rd_valid;
	int                         n_mismatch;
	int                         num_checks;
	cfs_engine_model eng (.clock(clock), .evt(evt));
	cfs_protocol_status dut (.clock(clock), .rst(rst), .evt(evt), .lvl(lvl),
		.delay_comp_offset(offset), .host(host), .rd_data(rd_data), .rd_valid(rd_valid));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [31:0] exp);
		@(posedge clock);
		host.rd <= 1'b1;
		@(posedge clock);
		host.rd <= 1'b0;
		#1;
		check({31'h0, rd_valid}, 32'h1);
		check(rd_data, exp);
	endtask
	task automatic wr(input logic [31:0] v);
		@(posedge clock);
		host.wr <= 1'b1;
		host.wdata <= v;
		@(posedge clock);
		host.wr <= 1'b0;
	endtask
	task automatic sc_flags();
		rd(32'h00000707);
		eng.send(18'h20000);
		rd(32'h00004707);
		rd(32'h00000707);
		eng.send(18'h18000);
		rd(32'h00003707);
		wr(32'hFFFFFFFF);
		rd(32'h00001707);
		eng.send(18'h14000);
		rd(32'h00002F07);
		wr(32'h00002000);
		rd(32'h00000F07);
	endtask
	task automatic sc_delay();
		eng.send(18'h00190);
		rd(32'h00300F07);
		@(posedge clock);
		offset <= 7'h05;
		eng.send(18'h00190);
		rd(32'h00150F07);
		eng.send(18'h001FD);
		rd(32'h007F0F07);
		eng.send(18'h00101);
		rd(32'h007F0F07);
	endtask
	task automatic sc_codes();
		for (int i = 0; i < 7; i++) begin
			eng.send({6'h01, i[2:0], 9'h000});
			rd(32'h007F0F00 | 32'(i));
		end
		eng.send(18'h02000);
		eng.send(18'h01C00);
		rd(32'h007F0E07);
		eng.send(18'h03000);
		rd(32'h007F0807);
	endtask
	task automatic sc_bus_off();
		@(posedge clock);
		lvl <= '{bus_off: 1'b1, warning: 1'b1, passive: 1'b1, activity: 2'h3};
		rd(32'h007F0FFF);
		@(posedge clock);
		lvl <= '{bus_off: 1'b0, warning: 1'b0, passive: 1'b1, activity: 2'h1};
		rd(32'h007F0F2F);
	endtask
	task automatic sc_reset();
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		#1;
		check(rd_data, 32'h00000707);
		check({31'h0, rd_valid}, 32'h0);
		@(posedge clock);
		rst <= 1'b0;
		rd(32'h0000072F);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		host = '0;
		lvl = '0;
		offset = 7'h20;
		n_mismatch = 0;
		num_checks = 0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		sc_flags();
		sc_delay();
		sc_codes();
		sc_bus_off();
		sc_reset();
		complete_run();
	end
endmodule // testbench
`default_nettype wire
